// [src/cbpc_pkg.sv]
// constants, types and register layout of the core clock burst power control
package cbpc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned REF_PERIOD_NS = 30518;
  localparam int unsigned REF_TICK_CYC = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [9:0] REF_DIV_LAST = 10'(REF_TICK_CYC - 1);
  localparam logic [4:0] BURST_LAST = 5'h1E;
  localparam logic [4:0] WIDTH_FULL = 5'h1F;
  localparam int unsigned SHUTDN_CYC = 30;
  localparam logic [4:0] SHUTDN_LAST = 5'(SHUTDN_CYC - 1);
  localparam logic [4:0] SHUTDN_FIRST = 5'h01;
  localparam logic [7:0] ADDR_PGC = 8'h00;
  localparam logic [7:0] ADDR_PLL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int unsigned GE_BIT = 7;
  localparam int unsigned PLL_OFF_BIT = 3;
  localparam logic [1:0] WAKE_SEL_RST = 2'h3;
  localparam logic [6:0] WAKE_P0 = 7'h20;
  localparam logic [6:0] WAKE_P1 = 7'h30;
  localparam logic [6:0] WAKE_P2 = 7'h40;
  localparam logic [6:0] WAKE_P3 = 7'h60;

  typedef struct packed {
    logic en;
    logic [1:0] rsvd;
    logic [4:0] width;
  } cbpc_pgc_s;

  typedef struct packed {
    logic pll_enable;
    logic pll_clk_run;
    logic divider_run;
    logic asleep;
  } cbpc_clk_s;

  typedef enum logic [1:0] {
    GT_RUN = 2'b00,
    GT_REQ = 2'b01,
    GT_GATED = 2'b10
  } cbpc_gate_e;

  typedef enum logic [2:0] {
    SL_AWAKE = 3'b000,
    SL_SHUTDN = 3'b001,
    SL_ASLEEP = 3'b010,
    SL_WAKEWAIT = 3'b011,
    SL_RESTART = 3'b100
  } cbpc_sleep_e;

  function automatic logic [6:0] cbpc_wake_periods(input logic [1:0] sel);
    case (sel)
      2'h0: cbpc_wake_periods = WAKE_P0;
      2'h1: cbpc_wake_periods = WAKE_P1;
      2'h2: cbpc_wake_periods = WAKE_P2;
      default: cbpc_wake_periods = WAKE_P3;
    endcase
  endfunction
endpackage

// [src/cbpc_burst.sv]
// reference tick divider and 31-period burst slot comparator
`timescale 1ns/100ps
module cbpc_burst (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [4:0] width,
  output logic ref_tick,
  output logic on_slot,
  output logic [4:0] phase
);
  import cbpc_pkg::*;
  logic [9:0] div_r;

  // reference rate keeps running in every mode, sleep included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 10'h000;
    end else if (div_r == REF_DIV_LAST) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_r + 10'h001;
    end
  end

  assign ref_tick = (div_r == REF_DIV_LAST);

  // phase restarts while disabled so enabling with a nonzero width opens with an on-slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 5'h00;
    end else if (!enable) begin
      phase <= 5'h00;
    end else if (ref_tick) begin
      phase <= (phase == BURST_LAST) ? 5'h00 : phase + 5'h01;
    end
  end

  assign on_slot = (phase < width);

  property p_period_wrap;
    @(posedge pclk) disable iff (!presetn)
      enable && ref_tick && phase == BURST_LAST |=> phase == 5'h00;
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("burst phase did not wrap after 31 periods");
endmodule

// [src/cbpc_sleep.sv]
// sleep sequencer: delayed PLL stop and timed wake restart
`timescale 1ns/100ps
module cbpc_sleep (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pll_off,
  input wire logic [1:0] wake_sel,
  input wire logic ref_tick,
  input wire logic wake,
  output logic wake_taken,
  output cbpc_pkg::cbpc_clk_s clk_ctl,
  output cbpc_pkg::cbpc_sleep_e sl_st
);
  import cbpc_pkg::*;
  logic [4:0] sd_cnt_r;
  logic [6:0] wk_cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_st <= SL_AWAKE;
    end else begin
      case (sl_st)
        SL_AWAKE: if (pll_off) sl_st <= SL_SHUTDN;
        SL_SHUTDN: if (sd_cnt_r == SHUTDN_LAST) sl_st <= SL_ASLEEP;
        SL_ASLEEP: if (wake) sl_st <= SL_WAKEWAIT;
        SL_WAKEWAIT: begin
          if (ref_tick && wk_cnt_r == cbpc_wake_periods(wake_sel) - 7'h01) begin
            sl_st <= SL_RESTART;
          end
        end
        SL_RESTART: sl_st <= SL_AWAKE;
        default: sl_st <= SL_AWAKE;
      endcase
    end
  end

  // counting starts at one so the PLL drops 30 edges after the bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_cnt_r <= 5'h00;
    end else if (sl_st != SL_SHUTDN) begin
      sd_cnt_r <= SHUTDN_FIRST;
    end else begin
      sd_cnt_r <= sd_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_cnt_r <= 7'h00;
    end else if (sl_st != SL_WAKEWAIT) begin
      wk_cnt_r <= 7'h00;
    end else if (ref_tick) begin
      wk_cnt_r <= wk_cnt_r + 7'h01;
    end
  end

  assign wake_taken = (sl_st == SL_ASLEEP) && wake;
  always_comb begin
    clk_ctl.pll_enable = (sl_st != SL_ASLEEP);
    clk_ctl.pll_clk_run = (sl_st == SL_AWAKE) || (sl_st == SL_SHUTDN) ||
                          (sl_st == SL_RESTART);
    clk_ctl.divider_run = (sl_st == SL_AWAKE) || (sl_st == SL_SHUTDN);
    clk_ctl.asleep = (sl_st == SL_ASLEEP) || (sl_st == SL_WAKEWAIT);
  end

  property p_shutdown_delay;
    @(posedge pclk) disable iff (!presetn)
      $rose(sl_st == SL_SHUTDN) |-> ##28 clk_ctl.pll_enable ##1 !clk_ctl.pll_enable;
  endproperty
  a_shutdown_delay: assert property (p_shutdown_delay)
    else $error("PLL did not stop 30 cycles after pll off");

  sequence s_restart;
    clk_ctl.pll_clk_run && !clk_ctl.divider_run ##1 clk_ctl.divider_run;
  endsequence
  property p_restart_order;
    @(posedge pclk) disable iff (!presetn)
      sl_st == SL_WAKEWAIT && $past(sl_st) == SL_WAKEWAIT && !clk_ctl.pll_clk_run
      ##1 sl_st == SL_RESTART |-> s_restart;
  endproperty
  a_restart_order: assert property (p_restart_order)
    else $error("PLL clock and divider chain restarted out of order");

  property p_asleep_hold;
    @(posedge pclk) disable iff (!presetn)
      sl_st == SL_ASLEEP && !wake |=> sl_st == SL_ASLEEP;
  endproperty
  a_asleep_hold: assert property (p_asleep_hold)
    else $error("sleep left without a wake-up event");
endmodule

// [src/cbpc_power_control.sv]
// core clock burst power control: APB registers, bus handoff, gating
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module cbpc_power_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_pending,
  input wire logic core_bus_grant,
  input wire logic dma_busy,
  output logic core_clk_en,
  output logic core_bus_req,
  output logic dma_bus_grant,
  output logic sys_clk_en,
  output logic addr_hold,
  output cbpc_pkg::cbpc_clk_s clk_ctl
);
  import cbpc_pkg::*;

  cbpc_pgc_s pgc_r;
  logic gate_en_r;
  logic [4:0] width_r;
  logic pll_off_r;
  logic [1:0] wake_sel_r;
  cbpc_gate_e gt_st;
  cbpc_sleep_e sl_st;
  logic ref_tick;
  logic on_slot;
  logic [4:0] phase;
  logic wake;
  logic wake_taken;
  logic gate_req;
  logic mapped;
  logic wr_acc;
  logic wr_pgc;
  logic wr_pll;
  logic rd_setup;
  logic [31:0] rd_mux;

  // any pending interrupt request counts as wake-up
  assign wake = irq_pending;

  // zero-wait slave: every access ends in its first access cycle
  assign pready = 1'b1;
  assign mapped = (paddr == ADDR_PGC) || (paddr == ADDR_PLL) || (paddr == ADDR_STAT);
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite;
  assign wr_pgc = wr_acc && (paddr == ADDR_PGC);
  assign wr_pll = wr_acc && (paddr == ADDR_PLL);
  assign rd_setup = psel && !penable && !pwrite;

  // enable: wake wins over a same-cycle software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_en_r <= 1'b0;
    end else if (wake && (gate_en_r || wr_pgc)) begin
      gate_en_r <= 1'b0;
    end else if (wr_pgc) begin
      gate_en_r <= pwdata[GE_BIT];
    end
  end

  // fraction only moves on a software write, never on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_r <= WIDTH_FULL;
    end else if (wr_pgc) begin
      width_r <= pwdata[4:0];
    end
  end

  // reserved bits have no storage: writes are dropped, reads give zero
  assign pgc_r = {gate_en_r, 2'h0, width_r};

  // pll off: cleared by the wake that ends sleep, which beats a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_off_r <= 1'b0;
    end else if (wake_taken) begin
      pll_off_r <= 1'b0;
    end else if (wr_pll) begin
      pll_off_r <= pwdata[PLL_OFF_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_sel_r <= WAKE_SEL_RST;
    end else if (wr_pll) begin
      wake_sel_r <= pwdata[1:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_PGC: rd_mux = {24'h00_0000, pgc_r};
      ADDR_PLL: rd_mux = {28'h000_0000, pll_off_r, 1'b0, wake_sel_r};
      ADDR_STAT: rd_mux = {19'h0_0000, phase, 2'h0, gt_st, 1'b0, sl_st};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data caught in setup so it comes from a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  cbpc_burst u_burst (
    .pclk(pclk),
    .presetn(presetn),
    .enable(pgc_r.en),
    .width(pgc_r.width),
    .ref_tick(ref_tick),
    .on_slot(on_slot),
    .phase(phase)
  );

  cbpc_sleep u_sleep (
    .pclk(pclk),
    .presetn(presetn),
    .pll_off(pll_off_r),
    .wake_sel(wake_sel_r),
    .ref_tick(ref_tick),
    .wake(wake),
    .wake_taken(wake_taken),
    .clk_ctl(clk_ctl),
    .sl_st(sl_st)
  );

  // off-slot of an enabled burst asks to stop the core
  assign gate_req = pgc_r.en && !on_slot;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gt_st <= GT_RUN;
    end else begin
      case (gt_st)
        GT_RUN: if (gate_req) gt_st <= GT_REQ;
        GT_REQ: begin
          if (!gate_req) begin
            gt_st <= GT_RUN;
          end else if (core_bus_grant) begin
            gt_st <= GT_GATED;
          end
        end
        GT_GATED: begin
          // a running DMA access finishes before the core gets the bus back
          if (!gate_req && !dma_busy) begin
            gt_st <= GT_RUN;
          end
        end
        default: gt_st <= GT_RUN;
      endcase
    end
  end

  assign core_bus_req = (gt_st != GT_RUN);
  assign dma_bus_grant = (gt_st == GT_GATED);
  assign core_clk_en = (gt_st != GT_GATED) && clk_ctl.divider_run;
  // the peripheral clock follows only the PLL chain, never the burst gate
  assign sys_clk_en = clk_ctl.divider_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_hold <= 1'b0;
    end else begin
      addr_hold <= clk_ctl.asleep;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_reset_normal;
    $rose(presetn) |-> !pgc_r.en && gt_st == GT_RUN && pgc_r.width == WIDTH_FULL;
  endproperty
  a_reset_normal: assert property (p_reset_normal)
    else $error("block not in normal mode after reset");

  property p_enable_write;
    wr_pgc && !wake |=> pgc_r.en == $past(pwdata[GE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow software write");

  property p_width_write;
    wr_pgc |=> pgc_r.width == $past(pwdata[4:0]);
  endproperty
  a_width_write: assert property (p_width_write)
    else $error("burst fraction did not follow software write");

  property p_full_on;
    pgc_r.en && pgc_r.width == WIDTH_FULL |-> !gate_req;
  endproperty
  a_full_on: assert property (p_full_on)
    else $error("full fraction still asked to gate the core");

  sequence s_doze_held;
    pgc_r.en && pgc_r.width == 5'h00 && gt_st == GT_GATED && !wake;
  endsequence
  property p_doze;
    s_doze_held |=> !core_clk_en && dma_bus_grant;
  endproperty
  a_doze: assert property (p_doze)
    else $error("core clock ran in doze without wake-up");

  property p_wake_clears;
    wake && pgc_r.en |=> !pgc_r.en;
  endproperty
  a_wake_clears: assert property (p_wake_clears)
    else $error("wake-up did not clear gating enable");

  property p_width_kept;
    !wr_pgc |=> $stable(pgc_r.width);
  endproperty
  a_width_kept: assert property (p_width_kept)
    else $error("burst fraction changed without a write");

  sequence s_req_wait;
    gt_st == GT_RUN && gate_req ##1 core_bus_req && !core_bus_grant;
  endsequence
  property p_grant_first;
    s_req_wait |-> (core_clk_en || !clk_ctl.divider_run) && !dma_bus_grant;
  endproperty
  a_grant_first: assert property (p_grant_first)
    else $error("core clock stopped before bus grant");

  property p_dma_priority;
    gt_st == GT_GATED && dma_busy |=> !core_clk_en && dma_bus_grant;
  endproperty
  a_dma_priority: assert property (p_dma_priority)
    else $error("core resumed during a DMA access");

  property p_sys_clock;
    !core_clk_en && (sl_st == SL_AWAKE || sl_st == SL_SHUTDN) |-> sys_clk_en;
  endproperty
  a_sys_clock: assert property (p_sys_clock)
    else $error("system clock gated together with core clock");

  property p_wake_resume;
    gt_st == GT_GATED && wake && !dma_busy ##1 !dma_busy |=> core_clk_en || !clk_ctl.divider_run;
  endproperty
  a_wake_resume: assert property (p_wake_resume)
    else $error("core clock not restored after wake-up");

  property p_hold_sleep;
    clk_ctl.asleep |=> addr_hold;
  endproperty
  a_hold_sleep: assert property (p_hold_sleep)
    else $error("address hold not raised during sleep");

  property p_read_control;
    rd_setup && paddr == ADDR_PGC |=> prdata[GE_BIT] == $past(pgc_r.en) &&
      prdata[4:0] == $past(pgc_r.width) && prdata[6:5] == 2'h0 &&
      prdata[31:8] == 24'h00_0000;
  endproperty
  a_read_control: assert property (p_read_control)
    else $error("control register read back wrong");

  property p_read_pll;
    rd_setup && paddr == ADDR_PLL |=>
      prdata[PLL_OFF_BIT] == $past(pll_off_r) && prdata[1:0] == $past(wake_sel_r);
  endproperty
  a_read_pll: assert property (p_read_pll)
    else $error("pll control register read back wrong");

  property p_read_status;
    rd_setup && paddr == ADDR_STAT |=> prdata[2:0] == $past(sl_st) &&
      prdata[5:4] == $past(gt_st) && prdata[12:8] == $past(phase);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status register read back wrong");

  property p_unmapped_quiet;
    wr_acc && !mapped |=> $stable(pgc_r.width) && $stable(wake_sel_r);
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet)
    else $error("write to unmapped address changed a register");

  property p_pll_write;
    wr_pll && !wake_taken |=> pll_off_r == $past(pwdata[PLL_OFF_BIT]);
  endproperty
  a_pll_write: assert property (p_pll_write)
    else $error("pll off bit did not follow software write");

  property p_wake_sel_write;
    wr_pll |=> wake_sel_r == $past(pwdata[1:0]);
  endproperty
  a_wake_sel_write: assert property (p_wake_sel_write)
    else $error("wake delay select did not follow software write");

  property p_grant_gates;
    gt_st == GT_REQ && gate_req && core_bus_grant |=> dma_bus_grant && !core_clk_en;
  endproperty
  a_grant_gates: assert property (p_grant_gates)
    else $error("core clock not stopped after bus grant");

  property p_req_drop;
    gt_st == GT_REQ && !gate_req |=> !core_bus_req;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("bus request kept after the on-slot returned");

  sequence s_enable_rise;
    !pgc_r.en && gt_st == GT_RUN ##1 pgc_r.en;
  endsequence
  property p_enable_phase;
    s_enable_rise |-> phase == 5'h00;
  endproperty
  a_enable_phase: assert property (p_enable_phase)
    else $error("burst period did not restart on enable");

  property p_enable_full;
    s_enable_rise |=> core_bus_req == ($past(pgc_r.width) == 5'h00);
  endproperty
  a_enable_full: assert property (p_enable_full)
    else $error("enable did not open with an on-slot");

  property p_doze_entry;
    pgc_r.en && pgc_r.width == 5'h00 && gt_st == GT_RUN |=> core_bus_req;
  endproperty
  a_doze_entry: assert property (p_doze_entry)
    else $error("zero fraction did not request the bus");

  property p_sleep_clocks;
    clk_ctl.asleep |-> !core_clk_en && !sys_clk_en;
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("clock enabled during sleep");

  property p_wake_pll;
    sl_st == SL_ASLEEP && wake |=> clk_ctl.pll_enable && !pll_off_r;
  endproperty
  a_wake_pll: assert property (p_wake_pll)
    else $error("wake-up did not re-enable the PLL");

  property p_gate_only_core;
    gt_st == GT_GATED && sl_st == SL_AWAKE |-> sys_clk_en && !core_clk_en;
  endproperty
  a_gate_only_core: assert property (p_gate_only_core)
    else $error("burst gate touched the peripheral clock");
endmodule

// [dv/cbpc_bus_partner.sv]
// behavioural core and dma pair sharing the bus with the gating block
`timescale 1ns/100ps
module cbpc_bus_partner #(
  parameter int GRANT_DLY = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_bus_req,
  input wire logic dma_bus_grant,
  input wire logic dma_hold,
  output logic core_bus_grant,
  output logic dma_busy
);
  int cnt;

  // core finishes its bus cycle before yielding, so the grant lags the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      core_bus_grant <= 1'b0;
    end else if (!core_bus_req) begin
      cnt <= 0;
      core_bus_grant <= 1'b0;
    end else if (cnt >= GRANT_DLY) begin
      core_bus_grant <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // dma only runs an access once it owns the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_busy <= 1'b0;
    end else begin
      dma_busy <= dma_bus_grant && dma_hold;
    end
  end
endmodule

// [dv/test_cbpc_power_control.sv]
// register-level bench for the core clock burst power control
`timescale 1ns/100ps
module test_cbpc_power_control;
  import cbpc_pkg::*;
  localparam int TICK = 762;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_pending = 1'b0;
  logic core_bus_grant;
  logic dma_busy;
  logic dma_hold = 1'b0;
  logic core_clk_en;
  logic core_bus_req;
  logic dma_bus_grant;
  logic sys_clk_en;
  logic addr_hold;
  cbpc_clk_s clk_ctl;
  int num_errors = 0;
  int compares = 0;
  int n;
  logic [31:0] rd;
  logic err;

  always #20 pclk = ~pclk;

  cbpc_power_control i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pending(irq_pending), .core_bus_grant(core_bus_grant),
    .dma_busy(dma_busy), .core_clk_en(core_clk_en), .core_bus_req(core_bus_req),
    .dma_bus_grant(dma_bus_grant), .sys_clk_en(sys_clk_en), .addr_hold(addr_hold),
    .clk_ctl(clk_ctl));

  cbpc_bus_partner #(.GRANT_DLY(3)) i_partner (.pclk(pclk), .presetn(presetn),
    .core_bus_req(core_bus_req), .dma_bus_grant(dma_bus_grant), .dma_hold(dma_hold),
    .core_bus_grant(core_bus_grant), .dma_busy(dma_busy));

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // read data and error are taken only at the edge that sees pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: sig = core_clk_en;
      1: sig = clk_ctl.pll_enable;
      default: sig = sys_clk_en;
    endcase
  endfunction

  // counts edges until the level shows, sampled just after each edge
  task automatic wait_for(input int s, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (sig(s) !== lvl && cnt < lim) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
    if (sig(s) !== lvl) begin
      num_errors++;
      $display("wrong value level of signal %0d expected %b seen %b", s, lvl, sig(s));
    end
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("core clock after reset", 1, core_clk_en);
    apb(1'b0, ADDR_PGC, 32'h0);
    chk("control reset", 32'h1F, rd);
    apb(1'b0, ADDR_PLL, 32'h0);
    chk("pll control reset", 32'h3, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped error", 1, err);
    apb(1'b1, 8'h0C, 32'h0000_00FF);
    chk("unmapped write error", 1, err);
    // burst of three slots, then the bus goes to dma
    apb(1'b1, ADDR_PGC, 32'h83);
    dma_hold <= 1'b1;
    wait_for(0, 1'b0, 4 * TICK, n);
    chk_rng("on-time cycles", 2 * TICK, 3 * TICK + 12, n);
    chk("dma grant when gated", 1, dma_bus_grant);
    chk("bus request when gated", 1, core_bus_req);
    chk("peripheral clock", 1, sys_clk_en);
    @(posedge pclk);
    irq_pending <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("core held by dma", 0, core_clk_en);
    apb(1'b0, ADDR_PGC, 32'h0);
    chk("enable cleared", 32'h03, rd);
    dma_hold <= 1'b0;
    wait_for(0, 1'b1, 10, n);
    chk("core after dma", 1, core_clk_en);
    @(posedge pclk);
    irq_pending <= 1'b0;
    // doze by zero width
    apb(1'b1, ADDR_PGC, 32'h80);
    wait_for(0, 1'b0, 20, n);
    chk("doze entered", 0, core_clk_en);
    repeat (2 * TICK) @(posedge pclk);
    chk("doze holds", 0, core_clk_en);
    irq_pending <= 1'b1;
    wait_for(0, 1'b1, 10, n);
    chk("doze wake", 1, core_clk_en);
    apb(1'b0, ADDR_PGC, 32'h0);
    chk("width kept", 32'h00, rd);
    irq_pending <= 1'b0;
    // sleep with the shortest wake delay
    apb(1'b1, ADDR_PLL, 32'h08);
    wait_for(1, 1'b0, 60, n);
    chk_rng("pll stop delay", SHUTDN_CYC, SHUTDN_CYC, n);
    wait_for(2, 1'b0, 20, n);
    chk("peripheral clock asleep", 0, sys_clk_en);
    repeat (100) @(posedge pclk);
    chk("still asleep", 0, sys_clk_en);
    chk("address held", 1, addr_hold);
    chk("pll clock stopped", 0, clk_ctl.pll_clk_run);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("status asleep", 32'h2, rd);
    irq_pending <= 1'b1;
    wait_for(2, 1'b1, 33 * TICK, n);
    chk_rng("wake delay", 31 * TICK, 32 * TICK + 8, n);
    chk("pll back", 1, clk_ctl.pll_enable);
    @(posedge pclk);
    irq_pending <= 1'b0;
    apb(1'b0, ADDR_PLL, 32'h0);
    chk("pll off cleared", 32'h0, rd);
    // second reset taken while dozing
    apb(1'b1, ADDR_PGC, 32'h80);
    wait_for(0, 1'b0, 20, n);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("core clock after second reset", 1, core_clk_en);
    apb(1'b0, ADDR_PGC, 32'h0);
    chk("control after second reset", 32'h1F, rd);
    tally_and_finish();
  end
endmodule
